// file: logic/control_signal_selector.sv

`include "csel_map.svh"

module control_signal_selector #(
  parameter int NUM_SEL = 4
) (
  // clock and reset
  input  wire logic                      CLOCK,
  input  wire logic                      RST,
  // avalon-mm slave
  input  wire logic [5:0]                AVS_ADDRESS,
  input  wire logic                      AVS_READ,
  input  wire logic                      AVS_WRITE,
  input  wire logic [31:0]               AVS_WRITEDATA,
  input  wire logic [3:0]                AVS_BYTEENABLE,
  output logic      [31:0]               AVS_READDATA,
  output logic                           AVS_WAITREQUEST,
  // drive monitoring conditions
  input  wire csel_pkg::drive_status_t   DRIVE_STATUS,
  // terminal pins
  input  wire csel_pkg::pins_t           PINS,
  // remote mode from the communication interface
  input  wire logic                      REMOTE_MODE,
  input  wire logic [7:0]                REMOTE_IN,
  // selected bits
  output logic      [NUM_SEL-1:0]        SEL_OUT,
  output logic                           DIGITAL_OUTPUT_ONE,
  output logic                           RELAY_OUTPUT,
  output logic                           DIGITAL_OUTPUT_THREE,
  output logic                           MULTIFUNCTION_OUTPUT
);

  typedef struct packed {
    csel_pkg::pins_t                    sync1;
    csel_pkg::pins_t                    sync2;
    csel_pkg::code_t [NUM_SEL-1:0]      sel_code;
    csel_pkg::code_t                    src_out1;
    csel_pkg::code_t                    src_relay;
    csel_pkg::code_t                    src_out3;
    csel_pkg::code_t                    src_mfo;
    csel_pkg::mode_t                    mode;
    logic [NUM_SEL-1:0]                 sel_out;
    logic                               out1;
    logic                               relay;
    logic                               out3;
    logic                               mfo;
    csel_pkg::bus_phase_t               phase;
    logic                               waitreq;
    logic [31:0]                        rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // merge a write under its byte enables
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0]  be
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // every code that does not mirror another selection
  // mirror codes fall to the default here, so a mirror chosen as an output source
  // reads zero and no loop through the output registers can form
  function automatic logic pick(
    input csel_pkg::code_t         c,
    input logic [7:0]              dig,
    input csel_pkg::drive_status_t s,
    input csel_pkg::pins_t         p,
    input csel_pkg::mode_t         m
  );
    logic                 b;
    logic [2:0]           idx;
    csel_pkg::code_t      off;
    b   = 1'b0;
    off = c - `C_IN_BASE;
    idx = off[2:0];
    if (c >= `C_IN_BASE && c < `C_IN_BASE + `C_IN_CNT) begin
      b = dig[idx];
    end else if (c >= `C_INV_BASE && c < `C_INV_BASE + `C_IN_CNT) begin
      off = c - `C_INV_BASE;
      idx = off[2:0];
      b   = ~dig[idx];
    end else begin
      case (c)
        `C_SET_FREQ: begin
          b = s.freq_above;
        end
        `C_IXT: begin
          b = s.ixt_overload;
        end
        `C_HEAT_SINK: begin
          b = s.heat_sink_warn;
        end
        `C_INSIDE: begin
          b = s.inside_warn;
        end
        `C_MOTOR_TEMP: begin
          b = s.motor_temp_warn;
        end
        `C_GENERAL: begin
          b = s.general_warn;
        end
        `C_OVERTEMP: begin
          b = s.heat_sink_warn | s.inside_warn;
        end
        `C_REF_PCT: begin
          b = s.ref_pct_reached;
        end
        `C_MAINS_FAIL: begin
          b = s.mains_failed & s.mains_ctrl_active;
        end
        `C_BREAKER: begin
          b = s.breaker_trip;
        end
        `C_APPL_MASK: begin
          b = s.appl_mask_warn;
        end
        `C_BACKLASH: begin
          b = s.backlash_ok;
        end
        `C_SVC_DC: begin
          b = s.dc_service_due & (m.dc_svc_mode == `SVC_ALARM);
        end
        `C_SVC_FAN: begin
          b = s.fan_service_due & (m.fan_svc_mode == `SVC_ALARM);
        end
        `C_SAFE_A_INV: begin
          b = ~p.safe_enable_a;
        end
        `C_SAFE_B_INV: begin
          b = ~p.safe_enable_b;
        end
        `C_SAFE_A: begin
          b = p.safe_enable_a;
        end
        `C_SAFE_B: begin
          b = p.safe_enable_b;
        end
        `C_POWER_ON: begin
          b = s.mains_on & s.precharge_done;
        end
        `C_ENERGY_SAVE: begin
          b = s.energy_trigger & ((m.energy_mode == `ES_MANUAL) |
                                  (m.energy_mode == `ES_AUTO));
        end
        default: begin
          b = 1'b0;
        end
      endcase
    end
    return b;
  endfunction : pick

  // reset image: everything low, bus busy until released
  // waitrequest stays high in reset, so no access can complete while the block is held
  localparam state_t RESET_STATE = '{
    sync1:     '0,
    sync2:     '0,
    sel_code:  {NUM_SEL{`RST_CODE}},
    src_out1:  `RST_CODE,
    src_relay: `RST_CODE,
    src_out3:  `RST_CODE,
    src_mfo:   `RST_CODE,
    mode:      `RST_MODE,
    sel_out:   '0,
    out1:      1'b0,
    relay:     1'b0,
    out3:      1'b0,
    mfo:       1'b0,
    phase:     csel_pkg::BUS_IDLE,
    waitreq:   1'b1,
    rdata:     32'h0000_0000
  };

  // combinational helpers, each given a value on every pass
  csel_pkg::pins_t pin;
  logic [7:0]      dig;
  logic [3:0]      mir;
  logic [31:0]     rword;
  logic [31:0]     wword;
  logic            hit;

  always_comb begin
    st_nxt = st_r;
    // pins pass two flops; only the second stage feeds logic
    st_nxt.sync1 = PINS;
    st_nxt.sync2 = st_r.sync1;
    pin = st_r.sync2;

    // codes 70..77: release needs both safe enables; remote mode overrides
    // codes 76 and 77 take the multifunction pins as plain digital inputs;
    // their analogue and polarity modes are left to the terminal logic
    if (REMOTE_MODE) begin
      dig = REMOTE_IN;
    end else begin
      dig = {pin.mfi_in, pin.digital_in,
             pin.safe_enable_a & pin.safe_enable_b};
    end

    // output sources; a mirror code chosen as a source reads zero
    mir[0] = pick(st_r.src_out1, dig, DRIVE_STATUS, pin, st_r.mode);
    mir[1] = pick(st_r.src_relay, dig, DRIVE_STATUS, pin, st_r.mode);
    mir[2] = pick(st_r.src_out3, dig, DRIVE_STATUS, pin, st_r.mode);
    mir[3] = pick(st_r.src_mfo, dig, DRIVE_STATUS, pin, st_r.mode);
    st_nxt.out1  = mir[0];
    st_nxt.relay = mir[1];
    st_nxt.out3  = mir[2];
    st_nxt.mfo   = mir[3];

    // one registered bit for each consumer
    // mirrors reuse the same-cycle source value, so a mirror and its output
    // register change on the same edge instead of one cycle apart
    for (int i = 0; i < NUM_SEL; i++) begin
      case (st_r.sel_code[i])
        `C_MIR_OUT1: begin
          st_nxt.sel_out[i] = mir[0];
        end
        `C_MIR_RELAY: begin
          st_nxt.sel_out[i] = mir[1];
        end
        `C_MIR_OUT3: begin
          st_nxt.sel_out[i] = mir[2];
        end
        `C_MIR_MFO: begin
          st_nxt.sel_out[i] = mir[3];
        end
        default: begin
          st_nxt.sel_out[i] = pick(st_r.sel_code[i], dig, DRIVE_STATUS,
                                   pin, st_r.mode);
        end
      endcase
    end

    // read decode; unmapped addresses read zero
    // limitation: more than four slots would collide with the source registers
    rword = 32'h0000_0000;
    hit   = 1'b0;
    for (int i = 0; i < NUM_SEL; i++) begin
      if (AVS_ADDRESS == `O_SEL0 + 6'(i) * `SEL_STRIDE) begin
        rword[`CODE_W-1:0] = st_r.sel_code[i];
        hit = 1'b1;
      end
    end
    if (!hit) begin
      case (AVS_ADDRESS)
        `O_SRC_OUT1: begin
          rword[`CODE_W-1:0] = st_r.src_out1;
        end
        `O_SRC_RELAY: begin
          rword[`CODE_W-1:0] = st_r.src_relay;
        end
        `O_SRC_OUT3: begin
          rword[`CODE_W-1:0] = st_r.src_out3;
        end
        `O_SRC_MFO: begin
          rword[`CODE_W-1:0] = st_r.src_mfo;
        end
        `O_MODE: begin
          rword[5:0] = st_r.mode;
        end
        // status is read-only; a write to its offset lands nowhere
        `O_STATUS: begin
          rword[NUM_SEL-1:0] = st_r.sel_out;
          rword[`STAT_OUT_LSB +: 4] = {st_r.mfo, st_r.out3,
                                       st_r.relay, st_r.out1};
        end
        default: begin
          rword = 32'h0000_0000;
        end
      endcase
    end
    wword = merge(rword, AVS_WRITEDATA, AVS_BYTEENABLE);

    // one wait cycle per access keeps readdata and waitrequest registered
    case (st_r.phase)
      csel_pkg::BUS_IDLE: begin
        if (AVS_READ || AVS_WRITE) begin
          st_nxt.phase   = csel_pkg::BUS_ACK;
          st_nxt.waitreq = 1'b0;
          st_nxt.rdata   = AVS_READ ? rword : 32'h0000_0000;
        end
      end
      csel_pkg::BUS_ACK: begin
        st_nxt.phase   = csel_pkg::BUS_IDLE;
        st_nxt.waitreq = 1'b1;
        // writes land on the edge the master sees waitrequest low
        // the master releases on that edge, so the idle phase that follows
        // never takes the same request a second time
        if (AVS_WRITE) begin
          for (int i = 0; i < NUM_SEL; i++) begin
            if (AVS_ADDRESS == `O_SEL0 + 6'(i) * `SEL_STRIDE) begin
              st_nxt.sel_code[i] = wword[`CODE_W-1:0];
            end
          end
          case (AVS_ADDRESS)
            `O_SRC_OUT1: begin
              st_nxt.src_out1 = wword[`CODE_W-1:0];
            end
            `O_SRC_RELAY: begin
              st_nxt.src_relay = wword[`CODE_W-1:0];
            end
            `O_SRC_OUT3: begin
              st_nxt.src_out3 = wword[`CODE_W-1:0];
            end
            `O_SRC_MFO: begin
              st_nxt.src_mfo = wword[`CODE_W-1:0];
            end
            `O_MODE: begin
              st_nxt.mode = wword[5:0];
            end
            default: begin
              st_nxt.mode = st_r.mode; // read-only or unmapped
            end
          endcase
        end
      end
      default: begin
        st_nxt.phase   = csel_pkg::BUS_IDLE;
        st_nxt.waitreq = 1'b1;
      end
    endcase
  end

  // drive status and remote inputs already run on this clock; only pins are synchronised
  // single state register, synchronous reset
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      st_r <= RESET_STATE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign SEL_OUT              = st_r.sel_out;
  assign DIGITAL_OUTPUT_ONE   = st_r.out1;
  assign RELAY_OUTPUT         = st_r.relay;
  assign DIGITAL_OUTPUT_THREE = st_r.out3;
  assign MULTIFUNCTION_OUTPUT = st_r.mfo;
  assign AVS_READDATA         = st_r.rdata;
  assign AVS_WAITREQUEST      = st_r.waitreq;

endmodule : control_signal_selector

// file: common/csel_map.svh
`ifndef CSEL_MAP_SVH
`define CSEL_MAP_SVH

// selection code width and the codes this selector answers
`define CODE_W        10
`define C_IN_BASE     10'h046
`define C_INV_BASE    10'h10e
`define C_IN_CNT      10'h008
`define C_SET_FREQ    10'h0a4
`define C_IXT         10'h0a5
`define C_HEAT_SINK   10'h0a6
`define C_INSIDE      10'h0a7
`define C_MOTOR_TEMP  10'h0a8
`define C_GENERAL     10'h0a9
`define C_OVERTEMP    10'h0aa
`define C_MIR_OUT1    10'h0af
`define C_MIR_RELAY   10'h0b0
`define C_MIR_OUT3    10'h0b1
`define C_REF_PCT     10'h0b2
`define C_MAINS_FAIL  10'h0b3
`define C_BREAKER     10'h0b4
`define C_MIR_MFO     10'h0b5
`define C_APPL_MASK   10'h0d7
`define C_BACKLASH    10'h0db
`define C_SVC_DC      10'h108
`define C_SVC_FAN     10'h109
`define C_SAFE_A_INV  10'h11c
`define C_SAFE_B_INV  10'h11d
`define C_SAFE_A      10'h124
`define C_SAFE_B      10'h125
`define C_POWER_ON    10'h143
`define C_ENERGY_SAVE 10'h1d7

// mode values
`define SVC_ALARM     2'h2
`define ES_MANUAL     2'h1
`define ES_AUTO       2'h2

// register byte offsets
`define O_SEL0        6'h00
`define SEL_STRIDE    6'h04
`define O_SRC_OUT1    6'h10
`define O_SRC_RELAY   6'h14
`define O_SRC_OUT3    6'h18
`define O_SRC_MFO     6'h1c
`define O_MODE        6'h20
`define O_STATUS      6'h24
`define STAT_OUT_LSB  8

// reset values
`define RST_CODE      10'h000
`define RST_MODE      6'h00

`endif

// file: common/csel_pkg.sv
`include "csel_map.svh"

package csel_pkg;

  typedef logic [`CODE_W-1:0] code_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_phase_t;

  // conditions from the drive monitoring logic, same clock
  typedef struct packed {
    logic freq_above;
    logic ixt_overload;
    logic heat_sink_warn;
    logic inside_warn;
    logic motor_temp_warn;
    logic general_warn;
    logic ref_pct_reached;
    logic mains_failed;
    logic mains_ctrl_active;
    logic breaker_trip;
    logic appl_mask_warn;
    logic backlash_ok;
    logic dc_service_due;
    logic fan_service_due;
    logic mains_on;
    logic precharge_done;
    logic energy_trigger;
  } drive_status_t;

  // terminal pins, asynchronous
  typedef struct packed {
    logic       safe_enable_a;
    logic       safe_enable_b;
    logic [4:0] digital_in;
    logic [1:0] mfi_in;
  } pins_t;

  typedef struct packed {
    logic [1:0] energy_mode;
    logic [1:0] fan_svc_mode;
    logic [1:0] dc_svc_mode;
  } mode_t;

endpackage : csel_pkg

// file: verification/sel_chk.sv
`include "csel_map.svh"

module sel_chk #(
  parameter int NUM_SEL = 4
) (
  // clock and reset
  input wire logic                    CLOCK,
  input wire logic                    RST,
  // register bus
  input wire logic [5:0]              AVS_ADDRESS,
  input wire logic                    AVS_READ,
  input wire logic                    AVS_WRITE,
  input wire logic [31:0]             AVS_WRITEDATA,
  input wire logic                    AVS_WAITREQUEST,
  // conditions and selected bits
  input wire csel_pkg::drive_status_t DRIVE_STATUS,
  input wire csel_pkg::pins_t         PINS,
  input wire logic [NUM_SEL-1:0]      SEL_OUT,
  input wire logic                    DIGITAL_OUTPUT_ONE
);
  csel_pkg::code_t sh_r;
  csel_pkg::mode_t md_r;
  logic [1:0]      cnt_r;
  logic            ok;

  // shadow of slot 0 and the mode word, taken at the accepting edge
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      sh_r <= `RST_CODE;
      md_r <= `RST_MODE;
      cnt_r <= 2'h0;
    end else begin
      cnt_r <= (cnt_r == 2'h3) ? cnt_r : cnt_r + 2'h1;
      if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == `O_SEL0) begin
        sh_r <= AVS_WRITEDATA[9:0];
      end
      if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == `O_MODE) begin
        md_r <= AVS_WRITEDATA[5:0];
      end
    end
  end
  // three clean edges, so no reset hides inside the $past depths below
  assign ok = (cnt_r == 2'h3);

  default clocking cb @(posedge CLOCK); endclocking

  sequence ack_s;
    !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endsequence

  reset_clear_a:
    assert property (disable iff (RST) $fell(RST) |-> SEL_OUT == '0 && !DIGITAL_OUTPUT_ONE && AVS_WAITREQUEST)
    else $error("outputs not clear after reset");
  bus_ack_a:
    assert property (disable iff (RST) (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && ok |=> ack_s)
    else $error("access not answered in one wait cycle");
  freq_sel_a:
    assert property (disable iff (RST) ok && $past(sh_r) == `C_SET_FREQ
      |-> SEL_OUT[0] == $past(DRIVE_STATUS.freq_above)) else $error("frequency code wrong");
  overtemp_a:
    assert property (disable iff (RST) ok && $past(sh_r) == `C_OVERTEMP
      |-> SEL_OUT[0] == $past(DRIVE_STATUS.heat_sink_warn | DRIVE_STATUS.inside_warn))
    else $error("overtemperature code wrong");
  service_a:
    assert property (disable iff (RST) ok && $past(sh_r) == `C_SVC_DC |-> SEL_OUT[0] ==
      ($past(DRIVE_STATUS.dc_service_due) && $past(md_r.dc_svc_mode) == `SVC_ALARM))
    else $error("service code wrong");
  energy_a:
    assert property (disable iff (RST) ok && $past(sh_r) == `C_ENERGY_SAVE |-> SEL_OUT[0] ==
      ($past(DRIVE_STATUS.energy_trigger) && $past(md_r.energy_mode) inside {`ES_MANUAL, `ES_AUTO}))
    else $error("energy saving code wrong");
  safe_inv_a:
    assert property (disable iff (RST) ok && $past(sh_r) == `C_SAFE_A_INV
      |-> SEL_OUT[0] == !$past(PINS.safe_enable_a, 3)) else $error("inverted enable wrong");
  mirror_a:
    assert property (disable iff (RST) ok && $past(sh_r) == `C_MIR_OUT1
      |-> SEL_OUT[0] == DIGITAL_OUTPUT_ONE) else $error("output mirror wrong");
  unknown_zero_a:
    assert property (disable iff (RST) ok && $past(sh_r) inside {`RST_CODE, 10'h3ff} |-> !SEL_OUT[0])
    else $error("unknown code not zero");
endmodule : sel_chk

bind control_signal_selector sel_chk #(.NUM_SEL(NUM_SEL)) chk (
  .CLOCK(CLOCK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .DRIVE_STATUS(DRIVE_STATUS), .PINS(PINS), .SEL_OUT(SEL_OUT), .DIGITAL_OUTPUT_ONE(DIGITAL_OUTPUT_ONE));

// file: verification/drive_side.sv
module drive_side (
  // clock
  input wire logic                    clk,
  // levels the bench wants
  input wire csel_pkg::drive_status_t want_s,
  input wire csel_pkg::pins_t         want_p,
  // levels seen by the selector
  output csel_pkg::drive_status_t     stat = '0,
  output csel_pkg::pins_t             pins = '0
);
  timeunit 1ns;
  timeprecision 1ns;
  // the monitor moves just after an edge; pins only on edges, a kind case
  always @(posedge clk) begin
    stat <= want_s;
    pins <= want_p;
  end
endmodule : drive_side

// file: verification/testbench.sv
`include "csel_map.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic [5:0] addr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rdd;
  logic wq;
  logic rmode = 1'b0;
  logic [7:0] rin = 8'h00;
  logic [3:0] sel;
  wire logic [3:0] outs;
  csel_pkg::drive_status_t want_s = '0;
  csel_pkg::drive_status_t stat;
  csel_pkg::pins_t want_p = '0;
  csel_pkg::pins_t pins;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  // single conditions and the status bit each one follows
  csel_pkg::code_t cd [10] = '{`C_SET_FREQ, `C_IXT, `C_HEAT_SINK, `C_INSIDE, `C_MOTOR_TEMP,
                               `C_GENERAL, `C_BREAKER, `C_APPL_MASK, `C_BACKLASH, `C_REF_PCT};
  int bt [10] = '{16, 15, 14, 13, 12, 11, 7, 6, 5, 10};
  // combined conditions: code, status, mode word, expected bit
  csel_pkg::code_t rc [15] = '{`C_OVERTEMP, `C_OVERTEMP, `C_OVERTEMP, `C_MAINS_FAIL, `C_MAINS_FAIL,
    `C_POWER_ON, `C_POWER_ON, `C_SVC_DC, `C_SVC_DC, `C_SVC_FAN, `C_SVC_FAN,
    `C_ENERGY_SAVE, `C_ENERGY_SAVE, `C_ENERGY_SAVE, `C_ENERGY_SAVE};
  logic [16:0] rs [15] = '{17'h04000, 17'h02000, 17'h19fff, 17'h00300, 17'h00200, 17'h00006,
    17'h00004, 17'h00010, 17'h00010, 17'h00008, 17'h00008, 17'h00001, 17'h00001, 17'h00001, 17'h00001};
  logic [5:0] rm [15] = '{6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h02, 6'h01, 6'h08, 6'h0c,
    6'h10, 6'h20, 6'h00, 6'h30};
  logic re [15] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  csel_pkg::code_t mc [4] = '{`C_MIR_OUT1, `C_MIR_RELAY, `C_MIR_OUT3, `C_MIR_MFO};

  drive_side far (.clk(CLOCK), .want_s(want_s), .want_p(want_p), .stat(stat), .pins(pins));

  control_signal_selector uut (
    .CLOCK(CLOCK), .RST(RST), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdd), .AVS_WAITREQUEST(wq),
    .DRIVE_STATUS(stat), .PINS(pins), .REMOTE_MODE(rmode), .REMOTE_IN(rin), .SEL_OUT(sel),
    .DIGITAL_OUTPUT_ONE(outs[3]), .RELAY_OUTPUT(outs[2]), .DIGITAL_OUTPUT_THREE(outs[1]),
    .MULTIFUNCTION_OUTPUT(outs[0]));

  always #50 CLOCK = ~CLOCK;

  // a hang counts as a mismatch
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      report_and_stop();
    end
  end

  task report_and_stop();
    $display("mismatches %0d, compares %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // one access, called just after a rising edge; the request stands until waitrequest
  // is seen low at a rising edge, then one idle edge keeps two calls apart
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    addr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    @(posedge CLOCK);
    while (wq !== 1'b0) @(posedge CLOCK);
    rdat = rdd;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge CLOCK);
  endtask : bus

  // select a code in slot 0, let pin synchronisers settle, then compare
  task automatic tc(input csel_pkg::code_t c, input logic e);
    bus(1'b1, `O_SEL0, {22'h0, c});
    repeat (4) @(posedge CLOCK);
    @(negedge CLOCK);
    `CHK($sformatf("code %0d", c), e, sel[0])
    @(posedge CLOCK);
  endtask : tc

  initial begin
    repeat (20) @(posedge CLOCK);
    RST <= 1'b0;
    @(negedge CLOCK);
    `CHK("sel after reset", 4'h0, sel)
    `CHK("wait after reset", 1'b1, wq)
    @(posedge CLOCK);
    bus(1'b0, 6'h3c, 32'h0);
    `CHK("unmapped", 32'h0, rdat)
    for (int i = 0; i < 10; i++) begin
      want_s <= 17'h1 << bt[i];
      tc(cd[i], 1'b1);
      want_s <= ~(17'h1 << bt[i]);
      tc(cd[i], 1'b0);
    end
    for (int i = 0; i < 15; i++) begin
      want_s <= rs[i];
      bus(1'b1, `O_MODE, {26'h0, rm[i]});
      tc(rc[i], re[i]);
    end
    want_s <= '1;
    tc(10'h3ff, 1'b0);
    want_s <= '0;
    want_p <= 9'h100;
    tc(`C_SAFE_A, 1'b1);
    tc(`C_SAFE_B, 1'b0);
    tc(`C_SAFE_A_INV, 1'b0);
    tc(`C_SAFE_B_INV, 1'b1);
    // codes 70 to 77: release pair, five digital inputs, two multifunction inputs
    for (int k = 0; k < 8; k++) begin
      want_p <= '0;
      rmode <= 1'b0;
      tc(csel_pkg::code_t'(`C_INV_BASE + k), 1'b1);
      want_p <= (k == 0) ? 9'h180 : (k < 6) ? 9'h002 << k : 9'h001 << (k % 2);
      tc(csel_pkg::code_t'(`C_IN_BASE + k), 1'b1);
      tc(csel_pkg::code_t'(`C_INV_BASE + k), 1'b0);
      want_p <= '0;
      rmode <= 1'b1;
      rin <= 8'h01 << k;
      tc(csel_pkg::code_t'(`C_IN_BASE + k), 1'b1);
    end
    rmode <= 1'b0;
    // sources of the four outputs are codes 164 to 167, one status bit each
    for (int i = 0; i < 4; i++) bus(1'b1, `O_SRC_OUT1 + 6'(4 * i), {22'h0, `C_SET_FREQ + 10'(i)});
    for (int i = 0; i < 4; i++) begin
      want_s <= 17'h10000 >> i;
      tc(mc[i], 1'b1);
      `CHK("outputs", 4'h8 >> i, outs)
      tc(mc[(i + 1) % 4], 1'b0);
    end
    bus(1'b1, 6'h04, {22'h0, `C_IXT});
    want_s <= 17'h08000;
    repeat (3) @(posedge CLOCK);
    @(negedge CLOCK);
    `CHK("slot one", 2'h2, sel[1:0])
    @(posedge CLOCK);
    bus(1'b0, 6'h04, 32'h0);
    `CHK("slot one code", {22'h0, `C_IXT}, rdat)
    bus(1'b0, `O_STATUS, 32'h0);
    `CHK("status word", 32'h0000_0202, rdat)
    // a second reset in mid-run must clear outputs and registers again
    RST <= 1'b1;
    @(posedge CLOCK);
    @(negedge CLOCK);
    `CHK("sel in reset", 4'h0, sel)
    `CHK("outs in reset", 4'h0, outs)
    @(posedge CLOCK);
    RST <= 1'b0;
    bus(1'b0, 6'h04, 32'h0);
    `CHK("slot one after reset", 32'h0, rdat)
    report_and_stop();
  end
endmodule : testbench
